/* verilog/sptr_pkg.sv */
// Constants for the per-port tuning register bank (offsets 80h..8Ch).
// Assumes 32-bit configuration words addressed by byte offset.
package sptr_pkg;
	localparam int DATA_W = 32;
	localparam int WORDS = 4;
	localparam logic [7:0] OFF_TUNE_A = 8'h80;
	localparam logic [7:0] OFF_TUNE_B = 8'h84;
	localparam logic [7:0] OFF_TUNE_C = 8'h88;
	localparam logic [7:0] OFF_TL_CTRL = 8'h8c;
	localparam logic [1:0] IDX_TUNE_A = 2'h0;
	localparam logic [1:0] IDX_TUNE_B = 2'h1;
	localparam logic [1:0] IDX_TUNE_C = 2'h2;
	localparam logic [1:0] IDX_TL_CTRL = 2'h3;
	localparam logic [31:0] RST_TUNE_A = 32'h000f0000;
	localparam logic [31:0] RST_TUNE_B = 32'h00000000;
	localparam logic [31:0] RST_TUNE_C_DN = 32'h33083333;
	localparam logic [31:0] RST_TL_DN = 32'h00791094;
	localparam int BIT_KEEP_CFG = 11;
	localparam int BIT_RATE_CTRL = 30;
	localparam int BIT_GEN1_ONLY = 31;
	localparam int BIT_ORDER_FROZEN = 6;
	localparam int BIT_CNT_LO = 8;
	localparam int CNT_W = 2;
	localparam int BIT_PORT_DIS = 10;
	localparam int BIT_RST_SEL = 11;
	localparam int SEC_BYTE_LO = 16;
	localparam int BIT_RETRAIN_DIS = 0;
	localparam logic [31:0] RST_TUNE_C_UP =
		RST_TUNE_C_DN | (32'h1 << BIT_RATE_CTRL);
	localparam logic [31:0] RST_TL_UP = RST_TL_DN | (32'h1 << BIT_RST_SEL);
	// Bits software may change, per word index
	localparam logic [3:0][31:0] SW_MASK =
		{32'h00000060, 32'hc0000000, 32'h00000000, 32'hffffffff};
	// Bits a default load may change; reserved bits are absent
	localparam logic [3:0][31:0] LOAD_MASK =
		{32'hbfff1fff, 32'hffffffff, 32'hffffffff, 32'hffffffff};
	localparam logic [31:0] EE_ONLY_MASK = 32'h00000040;
	// Global fields of the transaction word, honoured from upstream only
	localparam logic [31:0] TL_GLOBAL_MASK = 32'h3c0018ff;
	localparam int NUM_SRC = 3;
	localparam int SRC_EEPROM = 0;
	localparam int SRC_SIDEBAND = 1;
	localparam int SRC_TWOWIRE = 2;
	typedef enum logic {LINK_UP, LINK_DOWN} sptr_link_t;

	function automatic logic [3:0][31:0] sptrResetWords(input bit up);
		logic [3:0][31:0] w;
		w[IDX_TUNE_A] = RST_TUNE_A;
		w[IDX_TUNE_B] = RST_TUNE_B;
		w[IDX_TUNE_C] = up ? RST_TUNE_C_UP : RST_TUNE_C_DN;
		w[IDX_TL_CTRL] = up ? RST_TL_UP : RST_TL_DN;
		return w;
	endfunction
endpackage

/* verilog/sptr_ld_if.sv */
// Carries one accepted default-load word from the arbiter to the bank.
// Assumes a single sys_clk domain on both ends.
`timescale 1ns/1ns
`default_nettype none
interface sptr_ld_if #(parameter int PORT_W = 2);
	logic valid;
	logic [PORT_W-1:0] port;
	logic [1:0] index;
	logic [31:0] data;
	logic fromEeprom;
	modport src (output valid, port, index, data, fromEeprom);
	modport dst (input valid, port, index, data, fromEeprom);
endinterface
`default_nettype wire

/* verilog/sptr_load_arb.sv */
// Fixed-priority arbiter over the three default-load sources.
// Assumes sources hold their word until ready; EEPROM wins, then sideband.
`timescale 1ns/1ns
`default_nettype none
module sptr_load_arb
	import sptr_pkg::*;
#(
	parameter int PORT_W = 2
)
(
	input wire logic [NUM_SRC-1:0] srcValid,
	input wire logic [NUM_SRC-1:0][PORT_W-1:0] srcPort,
	input wire logic [NUM_SRC-1:0][7:0] srcOffset,
	input wire logic [NUM_SRC-1:0][31:0] srcData,
	output logic [NUM_SRC-1:0] srcReady,
	sptr_ld_if.src ld
);
	logic inBank;
	int sel;

	always_comb
	begin
		sel = NUM_SRC;
		srcReady = '0;
		for (int s = NUM_SRC - 1; s >= 0; s--)
			if (srcValid[s])
				sel = s;
		ld.valid = 1'b0;
		ld.port = '0;
		ld.index = '0;
		ld.data = '0;
		ld.fromEeprom = 1'b0;
		inBank = 1'b0;
		if (sel < NUM_SRC)
		begin
			srcReady[sel] = 1'b1;
			// Words outside the bank are consumed and dropped
			inBank = srcOffset[sel][7:4] == OFF_TUNE_A[7:4];
			ld.valid = inBank;
			ld.port = srcPort[sel];
			ld.index = srcOffset[sel][3:2];
			ld.data = srcData[sel];
			ld.fromEeprom = sel == SRC_EEPROM;
		end
	end
endmodule // sptr_load_arb
`default_nettype wire

/* verilog/sptr_restore_ctl.sv */
// Decides when upstream link-down wipes the runtime configuration.
// Assumes upLinkDown comes from switch-core logic on sys_clk.
`timescale 1ns/1ns
`default_nettype none
module sptr_restore_ctl
	import sptr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic upLinkDown,
	input wire logic keepCfg,
	output logic restore
);
	sptr_link_t state_q;

	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
			state_q <= LINK_UP;
		else
			state_q <= upLinkDown ? LINK_DOWN : LINK_UP;

	// One pulse on the falling link; keep decided at that instant
	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
			restore <= 1'b0;
		else
		begin
			unique case (state_q)
				LINK_UP: restore <= upLinkDown && !keepCfg;
				LINK_DOWN: restore <= 1'b0;
			endcase
		end
endmodule // sptr_restore_ctl
`default_nettype wire

/* verilog/sptr_tuning_bank.sv */
// Per-port tuning register bank at 80h..8Ch for all switch ports.
// Assumes port 0 is upstream; config accesses and loads on sys_clk.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Defaults loadable from sideband, two-wire or EEPROM.
// - Config reset on upstream link-down unless kept.
// - Rate-change bit resets 1 upstream, 0 downstream.
// - Writable first-generation-only bit, reset 0, loadable.
// - Ordering-frozen-disable turns off relaxed ordering.
// - Ordering-frozen-disable default changes by EEPROM only.
// - Two-bit rate-change attempt count, reset 00b.
// - Port-disable bit disables its port.
// - Reset-select acts upstream only; up 1, down 0.
// - Secondary byte bit 0 disables error retrain; 79h.
// - Global fields taken from upstream copy only.
module sptr_tuning_bank
	import sptr_pkg::*;
#(
	parameter int NUM_PORTS = 4,
	parameter int PORT_W = 2
)
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cfgReq,
	input wire logic cfgWrite,
	input wire logic [PORT_W-1:0] cfgPort,
	input wire logic [7:0] cfgOffset,
	input wire logic [3:0] cfgByteEn,
	input wire logic [31:0] cfgWrData,
	output logic [31:0] cfgRdData,
	output logic cfgAck,
	input wire logic eeValid,
	input wire logic [PORT_W-1:0] eePort,
	input wire logic [7:0] eeOffset,
	input wire logic [31:0] eeData,
	output logic eeReady,
	input wire logic sbValid,
	input wire logic [PORT_W-1:0] sbPort,
	input wire logic [7:0] sbOffset,
	input wire logic [31:0] sbData,
	output logic sbReady,
	input wire logic twValid,
	input wire logic [PORT_W-1:0] twPort,
	input wire logic [7:0] twOffset,
	input wire logic [31:0] twData,
	output logic twReady,
	input wire logic upLinkDown,
	output logic [NUM_PORTS-1:0] rateChangeControl,
	output logic [NUM_PORTS-1:0] firstGenOnlyCap,
	output logic [NUM_PORTS*CNT_W-1:0] rateChangeAttemptCount,
	output logic [NUM_PORTS-1:0] portDisable,
	output logic [NUM_PORTS-1:0] phyErrRetrainDisable,
	output logic orderingFrozenDisable,
	output logic upResetSelect,
	output logic cfgKeepOnLinkDown,
	output logic [31:0] globalTuneB,
	output logic [29:0] globalTuneC,
	output logic [31:0] globalTlCtrl
);
	// Elaboration check: port index must cover every port
	if (NUM_PORTS < 2 || NUM_PORTS > (1 << PORT_W))
	begin : gBadParams
		$error("sptr_tuning_bank: NUM_PORTS does not fit PORT_W");
	end

	sptr_ld_if #(.PORT_W(PORT_W)) ldBus ();

	logic [NUM_SRC-1:0] srcValid;
	logic [NUM_SRC-1:0][PORT_W-1:0] srcPort;
	logic [NUM_SRC-1:0][7:0] srcOffset;
	logic [NUM_SRC-1:0][31:0] srcData;
	logic [NUM_SRC-1:0] srcReady;

	always_comb
	begin
		srcValid[SRC_EEPROM] = eeValid;
		srcPort[SRC_EEPROM] = eePort;
		srcOffset[SRC_EEPROM] = eeOffset;
		srcData[SRC_EEPROM] = eeData;
		srcValid[SRC_SIDEBAND] = sbValid;
		srcPort[SRC_SIDEBAND] = sbPort;
		srcOffset[SRC_SIDEBAND] = sbOffset;
		srcData[SRC_SIDEBAND] = sbData;
		srcValid[SRC_TWOWIRE] = twValid;
		srcPort[SRC_TWOWIRE] = twPort;
		srcOffset[SRC_TWOWIRE] = twOffset;
		srcData[SRC_TWOWIRE] = twData;
	end

	assign eeReady = srcReady[SRC_EEPROM];
	assign sbReady = srcReady[SRC_SIDEBAND];
	assign twReady = srcReady[SRC_TWOWIRE];

	sptr_load_arb #(.PORT_W(PORT_W)) loadArb (
		.srcValid(srcValid),
		.srcPort(srcPort),
		.srcOffset(srcOffset),
		.srcData(srcData),
		.srcReady(srcReady),
		.ld(ldBus.src)
	);

	// Configuration access decode
	logic cfgInBank;
	logic [1:0] cfgIndex;
	logic [31:0] byteMask;
	logic [31:0] loadMask;
	logic restore;

	assign cfgInBank = cfgOffset[7:4] == OFF_TUNE_A[7:4] &&
		cfgOffset[1:0] == 2'h0;
	assign cfgIndex = cfgOffset[3:2];

	always_comb
	begin
		for (int b = 0; b < 4; b++)
			byteMask[b*8 +: 8] = {8{cfgByteEn[b]}};
	end

	// Ordering-frozen default is not reachable by the management buses
	// Only the transaction word carries the EEPROM-only bit
	assign loadMask = LOAD_MASK[ldBus.index] &
		((ldBus.fromEeprom || ldBus.index != IDX_TL_CTRL) ?
		32'hffffffff : ~EE_ONLY_MASK);

	logic [NUM_PORTS-1:0][3:0][31:0] curWords;

	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++)
		begin : gPort
			localparam logic [3:0][31:0] RST_W = sptrResetWords(p == 0);
			logic [3:0][31:0] cur_q;
			logic [3:0][31:0] cur_d;
			logic [3:0][31:0] dflt_q;
			logic ldHit;
			logic swHit;

			assign ldHit = ldBus.valid &&
				ldBus.port == PORT_W'(p);
			assign swHit = cfgReq && cfgWrite && cfgInBank &&
				cfgPort == PORT_W'(p);

			// Loaded values become the default restored on link-down
			always_ff @(posedge sys_clk or posedge rst)
				if (rst)
					dflt_q <= RST_W;
				else if (ldHit)
					dflt_q[ldBus.index] <=
						(dflt_q[ldBus.index] & ~loadMask) |
						(ldBus.data & loadMask);

			// Software lands after a same-cycle load so it is not lost
			always_comb
			begin
				cur_d = restore ? dflt_q : cur_q;
				if (ldHit)
					cur_d[ldBus.index] =
						(cur_d[ldBus.index] & ~loadMask) |
						(ldBus.data & loadMask);
				if (swHit)
					cur_d[cfgIndex] =
						(cur_d[cfgIndex] & ~(SW_MASK[cfgIndex] & byteMask)) |
						(cfgWrData & SW_MASK[cfgIndex] & byteMask);
			end

			always_ff @(posedge sys_clk or posedge rst)
				if (rst)
					cur_q <= RST_W;
				else
					cur_q <= cur_d;

			assign curWords[p] = cur_q;

			assign rateChangeControl[p] =
				cur_q[IDX_TUNE_C][BIT_RATE_CTRL];
			assign firstGenOnlyCap[p] =
				cur_q[IDX_TUNE_C][BIT_GEN1_ONLY];
			assign rateChangeAttemptCount[p*CNT_W +: CNT_W] =
				cur_q[IDX_TL_CTRL][BIT_CNT_LO +: CNT_W];
			assign portDisable[p] =
				cur_q[IDX_TL_CTRL][BIT_PORT_DIS];
			assign phyErrRetrainDisable[p] =
				cur_q[IDX_TL_CTRL][SEC_BYTE_LO + BIT_RETRAIN_DIS];
		end
	endgenerate

	// Global controls come only from the upstream copy
	assign orderingFrozenDisable =
		curWords[0][IDX_TL_CTRL][BIT_ORDER_FROZEN];
	assign upResetSelect = curWords[0][IDX_TL_CTRL][BIT_RST_SEL];
	assign cfgKeepOnLinkDown =
		curWords[0][IDX_TUNE_C][BIT_KEEP_CFG];
	assign globalTuneB = curWords[0][IDX_TUNE_B];
	assign globalTuneC = curWords[0][IDX_TUNE_C][29:0];
	assign globalTlCtrl =
		curWords[0][IDX_TL_CTRL] & TL_GLOBAL_MASK;

	sptr_restore_ctl restoreCtl (
		.sys_clk(sys_clk),
		.rst(rst),
		.upLinkDown(upLinkDown),
		.keepCfg(cfgKeepOnLinkDown),
		.restore(restore)
	);

	// Read path: one-cycle registered answer, zero outside the bank
	logic [31:0] rdData_d;
	logic cfgPortOk;

	assign cfgPortOk = 32'(cfgPort) < NUM_PORTS;

	always_comb
	begin
		rdData_d = '0;
		if (cfgInBank && cfgPortOk)
			rdData_d = curWords[cfgPort][cfgIndex];
	end

	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
			cfgAck <= 1'b0;
		else
			cfgAck <= cfgReq;

	always_ff @(posedge sys_clk or posedge rst)
		if (rst)
			cfgRdData <= '0;
		else if (cfgReq && !cfgWrite)
			cfgRdData <= rdData_d;
endmodule // sptr_tuning_bank
`default_nettype wire

/* verif/sptr_tuning_bank_chk.sv */
// Port-level assertions for the per-port tuning register bank.
// Assumes it is bound onto sptr_tuning_bank with the same parameters.
`timescale 1ns/1ns
`default_nettype none
module sptr_tuning_bank_chk
	import sptr_pkg::*;
#(
	parameter int NUM_PORTS = 4,
	parameter int PORT_W = 2
)
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cfgReq,
	input wire logic cfgWrite,
	input wire logic [PORT_W-1:0] cfgPort,
	input wire logic [7:0] cfgOffset,
	input wire logic [3:0] cfgByteEn,
	input wire logic [31:0] cfgWrData,
	input wire logic [31:0] cfgRdData,
	input wire logic cfgAck,
	input wire logic eeValid,
	input wire logic eeReady,
	input wire logic sbValid,
	input wire logic [PORT_W-1:0] sbPort,
	input wire logic [7:0] sbOffset,
	input wire logic sbReady,
	input wire logic twValid,
	input wire logic twReady,
	input wire logic [NUM_PORTS-1:0] rateChangeControl,
	input wire logic [NUM_PORTS-1:0] firstGenOnlyCap,
	input wire logic orderingFrozenDisable,
	input wire logic upResetSelect
);
	logic [31:0] wrData_q;
	logic anyLoad;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	assign anyLoad = eeValid | sbValid | twValid;
	// Write data a cycle back, since $past cannot be sliced
	always_ff @(posedge sys_clk)
		wrData_q <= cfgWrData;
	a_ack_one_after: assert property (cfgReq |=> cfgAck)
		else $error("no acknowledge after request");
	a_ack_no_req: assert property (!cfgReq |=> !cfgAck)
		else $error("acknowledge without request");
	a_ee_first: assert property (
		eeValid |-> eeReady && !sbReady && !twReady)
		else $error("load priority broken");
	a_cap_write: assert property (
		cfgReq && cfgWrite && cfgPort == '0 && cfgOffset == 8'h88 &&
		cfgByteEn[3] |=> {firstGenOnlyCap[0], rateChangeControl[0]}
		== wrData_q[31:30])
		else $error("capability bits not written");
	a_ofd_write: assert property (
		cfgReq && cfgWrite && cfgPort == '0 && cfgOffset == 8'h8c &&
		cfgByteEn[0] |=> orderingFrozenDisable == wrData_q[6])
		else $error("ordering control not written");
	a_ofd_sb_keep: assert property (
		sbValid && sbReady && sbPort == '0 && sbOffset == 8'h8c &&
		!cfgReq |=> $stable(orderingFrozenDisable))
		else $error("sideband changed ordering control");
	a_rsel_load_only: assert property (
		!anyLoad |=> $stable(upResetSelect))
		else $error("reset select changed without load");
	a_unmapped_zero: assert property (
		cfgReq && !cfgWrite && (cfgOffset[1:0] != '0 ||
		cfgOffset[7:4] != 4'h8) |=> cfgRdData == '0)
		else $error("unmapped read not zero");
	c_both_load: cover property (eeValid && sbValid);
	c_sb_take: cover property (sbValid && sbReady);
	c_write: cover property (cfgReq && cfgWrite);
endmodule // sptr_tuning_bank_chk
bind sptr_tuning_bank sptr_tuning_bank_chk #(.NUM_PORTS(NUM_PORTS),
	.PORT_W(PORT_W)) sptr_tuning_bank_chk_i (.*);
`default_nettype wire

/* verif/sptr_tuning_bank_tb_top.sv */
// Self-checking bench for the tuning register bank, four ports.
// Assumes default parameters with port 0 upstream.
`timescale 1ns/1ns
`default_nettype none
module sptr_tuning_bank_tb_top
	import sptr_pkg::*;
;
	typedef struct {logic [1:0] p; logic [7:0] o; logic [31:0] e;} sptr_row_t;
	logic sys_clk = 1'h0, rst = 1'h1, cfgReq = 1'h0, cfgWrite = 1'h0;
	logic [1:0] cfgPort = '0, eePort = '0, sbPort = '0, twPort = '0;
	logic [7:0] cfgOffset = '0, eeOffset = '0, sbOffset = '0, twOffset = '0;
	logic [3:0] cfgByteEn = '0;
	logic [31:0] cfgWrData = '0, eeData = '0, sbData = '0, twData = '0;
	logic eeValid = 1'h0, sbValid = 1'h0, twValid = 1'h0;
	logic upLinkDown = 1'h0;
	logic [31:0] cfgRdData, rd, globalTuneB, globalTlCtrl;
	logic cfgAck, eeReady, sbReady, twReady, orderingFrozenDisable;
	logic upResetSelect, cfgKeepOnLinkDown;
	logic [3:0] rateChangeControl, firstGenOnlyCap, portDisable;
	logic [3:0] phyErrRetrainDisable;
	logic [7:0] rateChangeAttemptCount;
	logic [29:0] globalTuneC;
	int err_count = 0, checked = 0, cyc = 0;
	sptr_row_t rw[11] = '{'{2'h0, 8'h80, 32'h000f0000},
		'{2'h0, 8'h84, '0}, '{2'h0, 8'h88, 32'h73083333},
		'{2'h0, 8'h8c, 32'h00791894}, '{2'h1, 8'h80, 32'h000f0000},
		'{2'h1, 8'h88, 32'h33083333}, '{2'h1, 8'h8c, 32'h00791094},
		'{2'h3, 8'h88, 32'h33083333}, '{2'h3, 8'h8c, 32'h00791094},
		'{2'h0, 8'h90, '0}, '{2'h0, 8'h86, '0}};

	sptr_tuning_bank sptr_tuning_bank_i (.*);

	always #20 sys_clk = ~sys_clk;

	task conclude;
		if (err_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// The whole run needs well under a thousand cycles
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 2000)
		begin
			err_count++;
			conclude();
		end
	end

	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			err_count++;
			$display("FAIL %0t seen %h want %h", $time, s, e);
		end
	endtask

	task cfg(input logic w, input logic [1:0] p, input logic [7:0] o,
		input logic [3:0] be, input logic [31:0] d);
		{cfgReq, cfgWrite, cfgPort, cfgOffset} <= {1'h1, w, p, o};
		{cfgByteEn, cfgWrData} <= {be, d};
		@(posedge sys_clk);
		cfgReq <= 1'h0;
		#1 rd = cfgRdData;
		chk(cfgAck, 1'h1);
		@(posedge sys_clk);
	endtask

	task rc(input logic [1:0] p, input logic [7:0] o, input logic [31:0] e);
		cfg(1'h0, p, o, '0, '0);
		chk(rd, e);
	endtask

	// Sideband gets the inverted word so arrival order shows in the result
	task ld(input logic [2:0] s, input logic [1:0] p, input logic [7:0] o,
		input logic [31:0] d);
		logic [2:0] pend;
		pend = s;
		{eePort, sbPort, twPort} <= {3{p}};
		{eeOffset, sbOffset, twOffset} <= {3{o}};
		{eeData, sbData, twData} <= {d, ~d, d};
		{twValid, sbValid, eeValid} <= s;
		repeat (6)
		begin
			@(posedge sys_clk);
			pend &= ~{twReady, sbReady, eeReady};
			{twValid, sbValid, eeValid} <= pend;
		end
		// Let the idle valids settle before the next load drives them
		@(posedge sys_clk);
		chk(pend, '0);
	endtask

	task rows;
		for (int i = 0; i < 11; i++)
			rc(rw[i].p, rw[i].o, rw[i].e);
	endtask

	task drop;
		upLinkDown <= 1'h1;
		repeat (3) @(posedge sys_clk);
		upLinkDown <= 1'h0;
	endtask

	initial
	begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'h0;
		chk({rateChangeControl, firstGenOnlyCap, portDisable, phyErrRetrainDisable,
			rateChangeAttemptCount, orderingFrozenDisable, upResetSelect,
			cfgKeepOnLinkDown}, 27'h0807802);
		rows();
		cfg(1'h1, 2'h0, 8'h80, 4'h5, '1);
		rc(2'h0, 8'h80, 32'h00ff00ff);
		cfg(1'h1, 2'h0, 8'h84, 4'hf, '1);
		rc(2'h0, 8'h84, '0);
		cfg(1'h1, 2'h0, 8'h88, 4'hf, '1);
		rc(2'h0, 8'h88, 32'hf3083333);
		chk({firstGenOnlyCap, rateChangeControl}, 8'h11);
		cfg(1'h1, 2'h0, 8'h88, 4'hf, '0);
		chk(rateChangeControl, '0);
		cfg(1'h1, 2'h1, 8'h8c, 4'hf, '1);
		rc(2'h1, 8'h8c, 32'h007910f4);
		chk(orderingFrozenDisable, '0);
		cfg(1'h1, 2'h0, 8'h8c, 4'h1, 32'h00000040);
		chk(orderingFrozenDisable, 1'h1);
		ld(3'h2, 2'h0, 8'h8c, '1);
		rc(2'h0, 8'h8c, 32'h00000040);
		ld(3'h1, 2'h0, 8'h8c, '0);
		chk(orderingFrozenDisable, '0);
		ld(3'h4, 2'h0, 8'h8c, 32'h3c000700);
		rc(2'h0, 8'h8c, 32'h3c000700);
		chk({portDisable, rateChangeAttemptCount, phyErrRetrainDisable,
			upResetSelect}, 17'h0207c);
		chk(globalTlCtrl, 32'h3c000000);
		ld(3'h3, 2'h1, 8'h80, 32'h12345678);
		rc(2'h1, 8'h80, 32'hedcba987);
		ld(3'h1, 2'h0, 8'h84, 32'h11112222);
		ld(3'h4, 2'h1, 8'h84, 32'h0000ffff);
		chk(globalTuneB, 32'h11112222);
		cfg(1'h1, 2'h2, 8'h80, 4'hf, 32'haaaa5555);
		drop();
		rc(2'h2, 8'h80, 32'h000f0000);
		rc(2'h1, 8'h80, 32'hedcba987);
		chk(rateChangeControl, 4'h1);
		ld(3'h1, 2'h0, 8'h88, 32'h73083b33);
		chk({cfgKeepOnLinkDown, globalTuneC}, 31'h73083b33);
		cfg(1'h1, 2'h2, 8'h80, 4'hf, 32'haaaa5555);
		drop();
		rc(2'h2, 8'h80, 32'haaaa5555);
		rst <= 1'h1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'h0;
		rows();
		conclude();
	end
endmodule // sptr_tuning_bank_tb_top
`default_nettype wire
